// file: hdl/floppy_function_sequencer.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module floppy_function_sequencer
    import ffs_pkg::*;
#(
    parameter int SEARCH_CYCLES = SEARCH_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 busAddr,
    input  wire logic [DATA_W-1:0]    busWdata,
    input  wire logic                 busWr,
    input  wire logic                 busRd,
    output logic      [DATA_W-1:0]    busRdata,
    input  wire logic                 busInit,
    input  wire logic                 powerOk,
    input  wire logic [1:0]           driveReady,
    input  ffs_media_rsp_t            mediaRsp,
    output ffs_media_req_t            mediaReq,
    output logic                      mediaWrEn,
    output logic      [7:0]           mediaWrByte,
    output logic                      mediaWrDeleted,
    output logic                      irq
);

    ffs_state_t              state_reg;
    ffs_fn_t                 fn_reg;
    logic [7:0]              sectorBuf [BUF_BYTES];
    logic [IDX_W:0]          count_reg;
    logic                    unit_reg;
    logic                    ie_reg;
    logic                    done_reg;
    logic                    tr_reg;
    logic                    err_reg;
    logic                    out_reg;
    logic [DATA_W-1:0]       status_reg;
    logic [DATA_W-1:0]       data_reg;
    logic [7:0]              errCode_reg;
    logic [7:0]              sector_reg;
    logic [7:0]              track_reg;
    logic                    addrPhase_reg;
    logic [15:0]             crc_reg;
    logic [31:0]             timer_reg;
    logic                    boot_reg;
    logic                    seekReq_reg;
    logic                    wrEn_reg;
    logic [7:0]              wrByte_reg;
    logic [1:0]              pwrSync_reg;
    logic [1:0]              initSync_reg;
    logic [1:0]              rdySync0_reg;
    logic [1:0]              rdySync1_reg;
    logic                    pwrPrev_reg;

    logic pwrOk;
    logic busInitS;
    logic csWrite;
    logic goCmd;
    logic swInit;
    logic dbWrite;
    logic dbRead;
    logic abort;
    logic powerUp;
    logic [7:0] bufOut;

    // power, initialize and drive-ready levels pass two flops before use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrSync_reg  <= 2'h0;
            initSync_reg <= 2'h0;
            rdySync0_reg <= 2'h0;
            rdySync1_reg <= 2'h0;
            pwrPrev_reg  <= 1'b0;
        end else begin
            pwrSync_reg  <= {pwrSync_reg[0], powerOk};
            initSync_reg <= {initSync_reg[0], busInit};
            rdySync0_reg <= {rdySync0_reg[0], driveReady[0]};
            rdySync1_reg <= {rdySync1_reg[0], driveReady[1]};
            pwrPrev_reg  <= pwrSync_reg[1];
        end
    end
    assign pwrOk    = pwrSync_reg[1];
    assign busInitS = initSync_reg[1];

    assign powerUp = pwrOk && !pwrPrev_reg;
    assign csWrite = busWr && (busAddr == ADDR_CS);
    // the host waits for done before issuing, so busy loads are dropped
    assign goCmd   = csWrite && busWdata[CS_GO] && done_reg
                     && !busWdata[CS_INIT];
    assign swInit  = csWrite && busWdata[CS_INIT];
    assign abort   = swInit || busInitS;
    assign dbWrite = busWr && (busAddr == ADDR_DB);
    assign dbRead  = busRd && (busAddr == ADDR_DB);
    assign bufOut  = sectorBuf[count_reg[IDX_W-1:0]];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ie_reg <= 1'b0;
        end else if (abort) begin
            ie_reg <= 1'b0;
        end else if (csWrite) begin
            ie_reg <= busWdata[CS_IE];
        end
    end

    // read port: command bits 0-4 and init read as zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busRdata <= '0;
        end else if (busRd && busAddr == ADDR_CS) begin
            busRdata <= '0;
            busRdata[CS_DONE] <= done_reg;
            busRdata[CS_IE]   <= ie_reg;
            busRdata[CS_TR]   <= tr_reg;
            busRdata[CS_ERR]  <= err_reg;
        end else if (busRd) begin
            busRdata <= data_reg;
        end else begin
            busRdata <= '0;
        end
    end

    // interrupt pulse on the rising edge of done
    logic donePrev_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            donePrev_reg <= 1'b0;
            irq          <= 1'b0;
        end else begin
            donePrev_reg <= done_reg;
            irq          <= done_reg && !donePrev_reg && ie_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (state_reg == ST_XFER_SHIFT && fn_reg == FN_FILL
            && !count_reg[IDX_W]) begin
            sectorBuf[count_reg[IDX_W-1:0]] <= data_reg[7:0];
        end else if (state_reg == ST_RD_DATA && mediaRsp.byteValid) begin
            sectorBuf[count_reg[IDX_W-1:0]] <= mediaRsp.byteIn;
        end
    end

    // main sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= ST_POWER_DOWN;
            fn_reg        <= FN_NONE;
            count_reg     <= '0;
            unit_reg      <= 1'b0;
            done_reg      <= 1'b0;
            tr_reg        <= 1'b0;
            err_reg       <= 1'b0;
            out_reg       <= 1'b0;
            status_reg    <= '0;
            data_reg      <= '0;
            errCode_reg   <= '0;
            sector_reg    <= '0;
            track_reg     <= '0;
            addrPhase_reg <= 1'b0;
            crc_reg       <= CRC_INIT;
            timer_reg     <= '0;
            boot_reg      <= 1'b0;
            seekReq_reg   <= 1'b0;
            wrEn_reg      <= 1'b0;
            wrByte_reg    <= '0;
        end else if (!pwrOk) begin
            state_reg   <= ST_POWER_DOWN;
            done_reg    <= 1'b0;
            tr_reg      <= 1'b0;
            seekReq_reg <= 1'b0;
            wrEn_reg    <= 1'b0;
        end else if (powerUp || abort) begin
            // boot read of drive 0 after power return or initialize
            done_reg      <= 1'b0;
            tr_reg        <= 1'b0;
            err_reg       <= 1'b0;
            status_reg    <= '0;
            boot_reg      <= 1'b1;
            unit_reg      <= 1'b0;
            fn_reg        <= FN_READ;
            sector_reg    <= BOOT_SECTOR;
            track_reg     <= BOOT_TRACK;
            seekReq_reg   <= 1'b1;
            timer_reg     <= '0;
            wrEn_reg      <= 1'b0;
            state_reg     <= ST_SEEK;
        end else begin
            wrEn_reg <= 1'b0;
            unique case (state_reg)
            ST_POWER_DOWN: state_reg <= ST_POWER_DOWN;
            ST_IDLE: begin
                if (dbWrite) begin
                    data_reg <= busWdata;
                end
                if (goCmd) begin
                    fn_reg    <= ffs_fn_t'(busWdata[CS_FN_LO +: 3]);
                    unit_reg  <= busWdata[CS_UNIT];
                    err_reg   <= 1'b0;
                    done_reg  <= 1'b0;
                    tr_reg    <= 1'b0;
                    count_reg <= '0;
                    addrPhase_reg <= 1'b0;
                    boot_reg  <= 1'b0;
                    unique case (ffs_fn_t'(busWdata[CS_FN_LO +: 3]))
                    FN_FILL, FN_EMPTY: begin
                        if (busWdata[CS_FN_LO +: 3] == FN_FILL) begin
                            status_reg <= '0;
                            out_reg    <= 1'b0;
                        end else begin
                            out_reg    <= 1'b1;
                        end
                        state_reg <= ST_XFER_WAIT;
                    end
                    FN_WRITE, FN_WRDEL: begin
                        state_reg <= ST_ADDR_WAIT;
                    end
                    FN_READ: begin
                        status_reg <= '0;
                        out_reg    <= 1'b0;
                        state_reg  <= ST_ADDR_WAIT;
                    end
                    FN_STATUS: begin
                        state_reg <= ST_FINISH;
                        status_reg[ES_DRDY] <= busWdata[CS_UNIT] ?
                            rdySync1_reg[1] : rdySync0_reg[1];
                        status_reg[ES_UNIT] <= busWdata[CS_UNIT];
                    end
                    FN_ERRCODE: begin
                        status_reg[ES_DEL:ES_CRC] <= '0;
                        out_reg   <= 1'b1;
                        data_reg  <= {8'h00, errCode_reg};
                        // done still drops a cycle, so an interrupt follows
                        state_reg <= ST_FINISH;
                    end
                    FN_NONE: begin
                        state_reg <= ST_FINISH;
                    end
                    endcase
                end
            end
            ST_XFER_WAIT: begin
                tr_reg <= 1'b1;
                if (fn_reg == FN_EMPTY) begin
                    data_reg <= {8'h00, bufOut};
                    if (tr_reg && dbRead) begin
                        tr_reg    <= 1'b0;
                        state_reg <= ST_XFER_SHIFT;
                    end
                end else if (tr_reg && dbWrite) begin
                    // reads of the data port here fall through unused
                    data_reg  <= busWdata;
                    tr_reg    <= 1'b0;
                    state_reg <= ST_XFER_SHIFT;
                end
            end
            ST_XFER_SHIFT: begin
                if (count_reg == IDX_W'(BUF_BYTES - 1)) begin
                    count_reg <= '0;
                    tr_reg    <= 1'b0;
                    state_reg <= ST_FINISH;
                end else begin
                    count_reg <= count_reg + 1'b1;
                    state_reg <= ST_XFER_WAIT;
                end
            end
            ST_ADDR_WAIT: begin
                tr_reg <= 1'b1;
                if (tr_reg && dbWrite) begin
                    tr_reg <= 1'b0;
                    if (!addrPhase_reg) begin
                        sector_reg <= busWdata[7:0];
                    end else begin
                        track_reg  <= busWdata[7:0];
                    end
                    state_reg <= ST_ADDR_SHIFT;
                end
            end
            ST_ADDR_SHIFT: begin
                addrPhase_reg <= 1'b1;
                if (addrPhase_reg) begin
                    seekReq_reg <= 1'b1;
                    timer_reg   <= '0;
                    state_reg   <= ST_SEEK;
                end else begin
                    state_reg   <= ST_ADDR_WAIT;
                end
            end
            ST_SEEK: begin
                tr_reg <= 1'b0;
                if (mediaRsp.seekDone) begin
                    seekReq_reg <= 1'b0;
                end
                if (mediaRsp.seekDone && !mediaRsp.trackFound) begin
                    err_reg     <= 1'b1;
                    errCode_reg <= ERR_CODE_SEEK;
                    state_reg   <= ST_FINISH;
                end else if (mediaRsp.sectorFound) begin
                    seekReq_reg <= 1'b0;
                    count_reg   <= '0;
                    crc_reg     <= CRC_INIT;
                    state_reg   <= (fn_reg == FN_READ) ? ST_RD_MARK
                                                       : ST_WR_DATA;
                end else if (timer_reg == 32'(SEARCH_CYCLES - 1)) begin
                    seekReq_reg <= 1'b0;
                    err_reg     <= 1'b1;
                    errCode_reg <= ERR_CODE_SEEK;
                    state_reg   <= ST_FINISH;
                end else begin
                    timer_reg <= timer_reg + 1'b1;
                end
            end
            ST_WR_DATA: begin
                wrEn_reg   <= 1'b1;
                wrByte_reg <= bufOut;
                crc_reg    <= crc_step(crc_reg, bufOut);
                count_reg  <= count_reg + 1'b1;
                if (count_reg == IDX_W'(BUF_BYTES - 1)) begin
                    count_reg <= '0;
                    state_reg <= ST_WR_CRC;
                end
            end
            ST_WR_CRC: begin
                wrEn_reg  <= 1'b1;
                count_reg <= count_reg + 1'b1;
                if (count_reg == '0) begin
                    wrByte_reg <= crc_reg[15:8];
                end else begin
                    wrByte_reg <= crc_reg[7:0];
                    count_reg  <= '0;
                    state_reg  <= ST_FINISH;
                end
            end
            ST_RD_MARK: begin
                status_reg[ES_DEL] <= mediaRsp.deletedMark;
                state_reg  <= ST_RD_DATA;
            end
            ST_RD_DATA: begin
                if (mediaRsp.byteValid) begin
                    crc_reg   <= crc_step(crc_reg, mediaRsp.byteIn);
                    count_reg <= count_reg + 1'b1;
                    if (count_reg == IDX_W'(BUF_BYTES - 1)) begin
                        count_reg <= '0;
                        state_reg <= ST_RD_CRC;
                    end
                end
            end
            ST_RD_CRC: begin
                if (mediaRsp.byteValid) begin
                    crc_reg   <= crc_step(crc_reg, mediaRsp.byteIn);
                    count_reg <= count_reg + 1'b1;
                    if (count_reg != '0) begin
                        state_reg  <= ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                tr_reg <= 1'b0;
                count_reg <= '0;
                if (fn_reg != FN_FILL && fn_reg != FN_EMPTY
                    && fn_reg != FN_ERRCODE) begin
                    data_reg <= status_reg;
                end
                if (fn_reg == FN_READ && crc_reg != 16'h0000
                    && !err_reg && !boot_reg) begin
                    status_reg[ES_CRC] <= 1'b1;
                    data_reg[ES_CRC]   <= 1'b1;
                    err_reg            <= 1'b1;
                    errCode_reg        <= ERR_CODE_CRC;
                end
                if (boot_reg) begin
                    status_reg[ES_INITD] <= 1'b1;
                    status_reg[ES_DRDY]  <= rdySync0_reg[1];
                    data_reg[ES_INITD]   <= 1'b1;
                    data_reg[ES_DRDY]    <= rdySync0_reg[1];
                    boot_reg             <= 1'b0;
                end
                done_reg  <= 1'b1;
                state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign mediaReq = '{seekReq: seekReq_reg, track: track_reg,
                        sector: sector_reg, unit: unit_reg,
                        headUnload: state_reg == ST_POWER_DOWN};
    assign mediaWrEn      = wrEn_reg;
    assign mediaWrByte    = wrByte_reg;
    assign mediaWrDeleted = (fn_reg == FN_WRDEL);

endmodule : floppy_function_sequencer

// file: hdl/ffs_pkg.sv
package ffs_pkg;

    localparam int BUF_BYTES = 128;
    localparam int IDX_W     = 7;
    localparam int DATA_W    = 16;

    // command word field positions
    localparam int CS_GO     = 0;
    localparam int CS_FN_LO  = 1;
    localparam int CS_UNIT   = 4;
    localparam int CS_DONE   = 5;
    localparam int CS_IE     = 6;
    localparam int CS_TR     = 7;
    localparam int CS_INIT   = 14;
    localparam int CS_ERR    = 15;

    // status word field positions
    localparam int ES_CRC    = 0;
    localparam int ES_INITD  = 2;
    localparam int ES_DEL    = 6;
    localparam int ES_DRDY   = 7;
    localparam int ES_UNIT   = 8;

    // port addresses: 0 command/status, 1 shared data
    localparam logic ADDR_CS = 1'b0;
    localparam logic ADDR_DB = 1'b1;

    // search time limit: two revolutions of 166.7 ms at 50 MHz
    localparam int CLK_MHZ   = 50;
    localparam int REV_US    = 166667;
    localparam int SEARCH_CYC = 2 * REV_US * CLK_MHZ;

    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0]  ERR_CODE_SEEK = 8'h70;
    localparam logic [7:0]  ERR_CODE_CRC  = 8'h80;
    localparam logic [7:0]  BOOT_SECTOR   = 8'h01;
    localparam logic [7:0]  BOOT_TRACK    = 8'h01;

    typedef enum logic [2:0] {
        FN_FILL, FN_EMPTY, FN_WRITE, FN_READ,
        FN_NONE, FN_STATUS, FN_WRDEL, FN_ERRCODE
    } ffs_fn_t;

    typedef enum {
        ST_IDLE, ST_XFER_WAIT, ST_XFER_SHIFT, ST_ADDR_WAIT, ST_ADDR_SHIFT,
        ST_SEEK, ST_WR_DATA, ST_WR_CRC, ST_RD_MARK, ST_RD_DATA, ST_RD_CRC,
        ST_FINISH, ST_POWER_DOWN
    } ffs_state_t;

    // media side request and answer
    typedef struct packed {
        logic       seekReq;
        logic [7:0] track;
        logic [7:0] sector;
        logic       unit;
        logic       headUnload;
    } ffs_media_req_t;

    typedef struct packed {
        logic       seekDone;
        logic       trackFound;
        logic       sectorFound;
        logic       byteValid;
        logic [7:0] byteIn;
        logic       deletedMark;
    } ffs_media_rsp_t;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = (r << 1) ^ CRC_POLY;
            end else begin
                r = r << 1;
            end
        end
        return r;
    endfunction : crc_step

endpackage : ffs_pkg

// file: tb/ffs_media_model.sv
`timescale 1ns/1ps
module ffs_media_model
    import ffs_pkg::*;
(
    input  wire logic     clk,
    input  ffs_media_req_t req,
    output ffs_media_rsp_t rsp
);
    logic [7:0]  b;
    logic [15:0] c;
    initial rsp = '0;
    initial forever begin
        @(posedge clk);
        if (req.seekReq === 1'b1) begin
            repeat (3) @(posedge clk);
            rsp.trackFound <= (req.track != 8'hFF);
            rsp.seekDone   <= 1'b1;
            @(posedge clk) rsp.seekDone <= 1'b0;
            repeat (3) @(posedge clk);
            // the sequencer drops its request once the track is found
            if (rsp.trackFound && req.sector != 8'h00) begin
                rsp.sectorFound <= 1'b1;
                rsp.deletedMark <= (req.sector == 8'h02);
                @(posedge clk) rsp.sectorFound <= 1'b0;
                // the mark is sampled one cycle before the first byte
                @(posedge clk);
                c = CRC_INIT;
                // good check bytes leave a zero residue; sector 7 is spoilt
                for (int i = 0; i < 130; i++) begin
                    b = (i < 128) ? (8'(i) ^ 8'h5A) :
                        (i == 128) ? c[15:8] :
                        (c[7:0] ^ 8'(req.sector == 8'h07));
                    for (int k = 7; k >= 0 && i < 128; k--) begin
                        c = {c[14:0], 1'b0}
                            ^ ((c[15] ^ b[k]) ? CRC_POLY : 16'h0000);
                    end
                    rsp.byteIn    <= b;
                    rsp.byteValid <= 1'b1;
                    @(posedge clk) rsp.byteValid <= 1'b0;
                    rsp.byteIn <= ~b;
                    @(posedge clk);
                end
            end
            while (req.seekReq === 1'b1) @(posedge clk);
        end
    end
endmodule : ffs_media_model

// file: tb/ffs_seq_assertions.sv
`timescale 1ns/1ps
module ffs_seq_checker
    import ffs_pkg::*;
#(
    parameter int SEARCH_CYCLES = 200
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              busAddr,
    input wire logic [DATA_W-1:0] busWdata,
    input wire logic              busWr,
    input wire logic              busRd,
    input logic      [DATA_W-1:0] busRdata,
    input wire logic              powerOk,
    input ffs_media_req_t         mediaReq,
    input logic                   mediaWrEn,
    input logic                   mediaWrDeleted,
    input logic                   irq
);
    int seekCnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) seekCnt <= 0;
        else seekCnt <= mediaReq.seekReq ? seekCnt + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_CS_WO: assert property (
        $past(busRd) && !$past(busAddr) |-> busRdata[4:0] == 5'h00)
        else $error("write-only command bits read back");
    AST_RDATA_IDLE: assert property (
        !$past(busRd) |-> busRdata == 16'h0000)
        else $error("read data outside its cycle");
    AST_IRQ_PULSE: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    AST_HEAD_UNLOAD: assert property (
        !powerOk [*4] |-> mediaReq.headUnload)
        else $error("head loaded without power");
    AST_UNLOAD_QUIET: assert property (
        mediaReq.headUnload |-> !mediaWrEn && !mediaReq.seekReq)
        else $error("media activity while powered down");
    AST_INIT_ABORT: assert property (
        busWr && !busAddr && busWdata[CS_INIT] |-> ##3 !mediaWrEn [*8])
        else $error("writing after initialize");
    AST_DEL_SRC: assert property (
        $rose(mediaWrDeleted) |-> $past(busWr) && !$past(busAddr)
            && $past(busWdata[3:0]) == 4'hD)
        else $error("deleted mark without deleted write");
    AST_SEARCH_BOUND: assert property (
        seekCnt <= SEARCH_CYCLES + 16)
        else $error("search outlived its limit");
endmodule : ffs_seq_checker
bind floppy_function_sequencer ffs_seq_checker
    #(.SEARCH_CYCLES(SEARCH_CYCLES)) chk (.clk, .rst_b, .busAddr,
    .busWdata, .busWr, .busRd, .busRdata, .powerOk, .mediaReq,
    .mediaWrEn, .mediaWrDeleted, .irq);

// file: tb/floppy_function_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("ERROR %0t mismatch", $time); end end
module floppy_function_sequencer_tb_top;
    import ffs_pkg::*;
    logic clk = 0, rst_b = 0, busAddr = 0, busWr = 0, busRd = 0;
    logic busInit = 0, powerOk = 0, mediaWrEn, mediaWrDeleted, irq;
    logic [15:0] busWdata = 0, busRdata, d, e;
    logic [1:0] driveReady = 2'b11;
    logic [7:0] mediaWrByte;
    ffs_media_req_t mediaReq;
    ffs_media_rsp_t mediaRsp;
    int fail_count = 0, total_checks = 0, irqs, wrs, dels;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        irqs += (irq === 1'b1);
        wrs  += (mediaWrEn === 1'b1);
        dels += (mediaWrDeleted === 1'b1);
    end
    floppy_function_sequencer #(.SEARCH_CYCLES(200)) uut (.clk, .rst_b,
        .busAddr, .busWdata, .busWr, .busRd, .busRdata, .busInit,
        .powerOk, .driveReady, .mediaRsp, .mediaReq, .mediaWrEn,
        .mediaWrByte, .mediaWrDeleted, .irq);
    ffs_media_model media (.clk, .req(mediaReq), .rsp(mediaRsp));
    task automatic wr(input logic a, input logic [15:0] v);
        busAddr <= a; busWdata <= v; busWr <= 1'b1;
        @(posedge clk) busWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic a, output logic [15:0] v);
        busAddr <= a; busRd <= 1'b1;
        @(posedge clk) busRd <= 1'b0;
        @(posedge clk) v = busRdata;
    endtask : rd
    task automatic waitF(input int b);
        int n;
        n = 0; e = 0;
        while (e[b] !== 1'b1 && n < 20000) begin rd(ADDR_CS, e); n++; end
        `CHK(e[b], 1'b1)
    endtask : waitF
    task automatic cmd(input logic [15:0] c, input bit a,
                       input logic [7:0] s, input logic [7:0] t);
        irqs = 0; wrs = 0; dels = 0;
        wr(ADDR_CS, c);
        if (a) begin
            waitF(CS_TR); wr(ADDR_DB, {8'h00, s});
            waitF(CS_TR); wr(ADDR_DB, {8'h00, t});
        end
        waitF(CS_DONE);
        rd(ADDR_DB, d);
    endtask : cmd
    task automatic t_boot;
        waitF(CS_DONE);
        cmd(16'h000B, 0, 0, 0);
        `CHK(d[ES_INITD], 1'b1)
        `CHK(d[ES_DRDY], 1'b1)
        $display("end boot");
    endtask : t_boot
    task automatic t_fill;
        wr(ADDR_CS, 16'h0011);
        for (int i = 0; i < 128; i++) begin
            waitF(CS_TR);
            if (i == 5) rd(ADDR_DB, d);
            if (i == 127) begin rd(ADDR_CS, e); `CHK(e[CS_DONE], 1'b0) end
            wr(ADDR_DB, {8'h00, 8'(i) ^ 8'hC3});
        end
        waitF(CS_DONE);
        $display("end fill");
    endtask : t_fill
    task automatic t_empty(input logic [7:0] x);
        wr(ADDR_CS, 16'h0013);
        for (int i = 0; i < 128; i++) begin
            waitF(CS_TR); rd(ADDR_DB, d);
            `CHK(d[7:0], 8'(i) ^ x)
        end
        waitF(CS_DONE);
        $display("end empty");
    endtask : t_empty
    task automatic t_write;
        cmd(16'h004D, 1, 8'h05, 8'h03);
        `CHK(wrs, 130)
        `CHK(irqs, 1)
        `CHK(dels > 0, 1'b1)
        cmd(16'h0045, 1, 8'h01, 8'hFF);
        `CHK(e[CS_ERR], 1'b1)
        `CHK(irqs, 1)
        cmd(16'h0005, 1, 8'h00, 8'h03);
        `CHK(e[CS_ERR], 1'b1)
        cmd(16'h000F, 0, 0, 0);
        `CHK(d[7:0], ERR_CODE_SEEK)
        $display("end write");
    endtask : t_write
    task automatic t_read;
        cmd(16'h0007, 1, 8'h02, 8'h03);
        `CHK(d[ES_DEL], 1'b1)
        `CHK(d[ES_CRC], 1'b0)
        `CHK(e[CS_ERR], 1'b0)
        cmd(16'h0007, 1, 8'h07, 8'h03);
        `CHK(d[ES_CRC], 1'b1)
        `CHK(e[CS_ERR], 1'b1)
        cmd(16'h0009, 0, 0, 0);
        `CHK(wrs, 0)
        driveReady <= 2'b10;
        cmd(16'h001B, 0, 0, 0);
        `CHK(d[ES_DRDY], 1'b1)
        `CHK(d[ES_UNIT], 1'b1)
        cmd(16'h000B, 0, 0, 0);
        `CHK(d[ES_DRDY], 1'b0)
        driveReady <= 2'b11;
        $display("end read");
    endtask : t_read
    task automatic t_init;
        wr(ADDR_CS, 16'h0001);
        wr(ADDR_CS, 16'h4000);
        repeat (4) @(posedge clk);
        t_boot;
        busInit <= 1'b1;
        repeat (4) @(posedge clk) busInit <= 1'b0;
        repeat (6) @(posedge clk);
        t_boot;
        powerOk <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(mediaReq.headUnload, 1'b1)
        powerOk <= 1'b1;
        repeat (6) @(posedge clk);
        t_boot;
        $display("end init");
    endtask : t_init
    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1; powerOk <= 1'b1;
        @(posedge clk);
        t_boot; t_fill; t_empty(8'hC3); t_empty(8'hC3);
        t_write; t_read; t_empty(8'h5A); t_init;
        wrap_up;
    end
    initial begin
        #600000;
        fail_count++;
        wrap_up;
    end
endmodule : floppy_function_sequencer_tb_top
